/* shared/csi_pkg.sv */
package csi_pkg;

  localparam int NUM_IDX = 8;
  localparam int NUM_CNT = 9;
  localparam int IDX_W = 4;
  localparam int Y_W = 12;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STORE_W = 14;

  // Index channels: cursor0, icon, scaler0, display0, cursor1, scaler1, display1, capture
  localparam logic [ADDR_W-1:0] IDX_OFS [NUM_IDX] = '{
    12'hb04, 12'hb14, 12'hb24, 12'hb34, 12'hb64, 12'hb74, 12'hb84, 12'hbe4
  };

  // Counter sources: cursor0, icon, scaler0, display0, cursor1, scaler1, display1,
  // linear transfer, capture
  localparam logic [ADDR_W-1:0] CNT_OFS [NUM_CNT] = '{
    12'hb0c, 12'hb1c, 12'hb2c, 12'hb3c, 12'hb6c, 12'hb7c, 12'hb8c, 12'hbdc, 12'hbec
  };

  // Channels that carry two indices and a buffering mode
  localparam logic [NUM_IDX-1:0] DBL_CHAN = 8'ha4;

  localparam int BUF1_LSB = 0;
  localparam int BUF2_LSB = 8;
  localparam int VSEL_BIT = 7;
  localparam int MODE_LSB = 12;
  localparam int MODE_W = 2;
  localparam int Y_LSB = 16;

  localparam logic [STORE_W-1:0] SIMPLE_MASK = 14'h008f;
  localparam logic [STORE_W-1:0] DBL_MASK = 14'h3f8f;
  localparam logic [STORE_W-1:0] IDX_RESET = 14'h0000;
  localparam logic [Y_W-1:0] Y_RESET = 12'h000;

  typedef enum logic [MODE_W-1:0] {
    CSI_MODE_BUF0,
    CSI_MODE_BUF1,
    CSI_MODE_ALT,
    CSI_MODE_RSVD
  } csi_dbuf_mode_t;

endpackage

/* design/csi_line_counter.sv */
`timescale 1ns/1ps
module csi_line_counter #(
  parameter int Y_W = csi_pkg::Y_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic line_strobe,
  input wire logic frame_strobe,
  input wire logic [Y_W-1:0] start_value,
  output logic [Y_W-1:0] count
);

  typedef struct packed {
    logic [Y_W-1:0] cnt;
  } csi_cnt_state_t;

  csi_cnt_state_t r_reg;
  csi_cnt_state_t r_next;

  always_comb begin
    r_next = r_reg;
    if (frame_strobe) begin
      r_next.cnt = start_value;
    end else if (line_strobe) begin
      r_next.cnt = r_reg.cnt + Y_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r_reg.cnt <= Y_W'(csi_pkg::Y_RESET);
    end else begin
      r_reg <= r_next;
    end
  end

  assign count = r_reg.cnt;

  line_advance_a: assert property (@(posedge core_clk) disable iff (!nrst)
    line_strobe && !frame_strobe |=> count == $past(count) + Y_W'(1))
    else $error("Counter did not advance on a line");

  frame_reload_a: assert property (@(posedge core_clk) disable iff (!nrst)
    frame_strobe |=> count == $past(start_value))
    else $error("Counter not reloaded at frame start");

endmodule

/* design/csi_top.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Every index register keeps a four-bit surface index in bits 3:0 that picks one of sixteen.
// - Bit 7 of an index register picks the frame source: display 0 when clear, display 1 when set.
// - Scaler 0, scaler 1 and capture keep a first index in bits 3:0 and a second in bits 11:8.
// - Those three also keep a two-bit buffering mode in bits 13:12.
// - Mode 0 always uses the first index and mode 1 always uses the second.
// - Mode 2 alternates between the two indices and mode 3 is reserved for software.
// - Each line counter steps by one per line and is reloaded at each frame start.
// - Nine line counters are readable and ignore writes.
// - A counter reads in bits 27:16 with every other bit zero.
module csi_top #(
  parameter int Y_W = csi_pkg::Y_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [csi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [csi_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [csi_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [csi_pkg::NUM_CNT-1:0] line_strobe,
  input wire logic [csi_pkg::NUM_CNT-1:0] frame_strobe,
  input wire logic [csi_pkg::NUM_CNT-1:0][Y_W-1:0] y_start,
  input wire logic [1:0] disp_frame_start,
  output logic [csi_pkg::NUM_IDX-1:0][csi_pkg::IDX_W-1:0] surface_index,
  output logic [csi_pkg::NUM_IDX-1:0] vsync_sel
);

  localparam int NI = csi_pkg::NUM_IDX;
  localparam int NC = csi_pkg::NUM_CNT;
  localparam int IW = csi_pkg::IDX_W;
  localparam int SW = csi_pkg::STORE_W;
  localparam int DW = csi_pkg::DATA_W;

  typedef struct packed {
    logic [NI-1:0][SW-1:0] idx;
    logic [NI-1:0] alt;
    logic [NI-1:0][IW-1:0] act;
    logic [NI-1:0] vsel;
    logic [DW-1:0] rdata;
  } csi_state_t;

  csi_state_t r_reg;
  csi_state_t r_next;
  logic [NC-1:0][Y_W-1:0] cnt;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cnt
      csi_line_counter #(
        .Y_W(Y_W)
      ) u_cnt (
        .core_clk(core_clk),
        .nrst(nrst),
        .line_strobe(line_strobe[g]),
        .frame_strobe(frame_strobe[g]),
        .start_value(y_start[g]),
        .count(cnt[g])
      );
    end
  endgenerate

  function automatic csi_pkg::csi_dbuf_mode_t mode_of(input logic [SW-1:0] v);
    return csi_pkg::csi_dbuf_mode_t'(v[csi_pkg::MODE_LSB +: csi_pkg::MODE_W]);
  endfunction

  // Reserved mode falls back to the first index so a bad setting still shows a valid surface
  function automatic logic [IW-1:0] pick_index(
    input logic [SW-1:0] v,
    input logic alt,
    input logic dbl
  );
    logic [IW-1:0] first;
    logic [IW-1:0] second;
    logic [IW-1:0] res;
    first = v[csi_pkg::BUF1_LSB +: IW];
    second = v[csi_pkg::BUF2_LSB +: IW];
    res = first;
    if (dbl) begin
      unique case (mode_of(v))
        csi_pkg::CSI_MODE_BUF0: res = first;
        csi_pkg::CSI_MODE_BUF1: res = second;
        csi_pkg::CSI_MODE_ALT: res = alt ? second : first;
        csi_pkg::CSI_MODE_RSVD: res = first;
      endcase
    end
    return res;
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.rdata = '0;
    for (int c = 0; c < NI; c++) begin
      // Flip once per frame of the chosen source
      if (csi_pkg::DBL_CHAN[c] && mode_of(r_reg.idx[c]) == csi_pkg::CSI_MODE_ALT &&
          disp_frame_start[r_reg.idx[c][csi_pkg::VSEL_BIT]]) begin
        r_next.alt[c] = ~r_reg.alt[c];
      end
      if (reg_wr && reg_addr == csi_pkg::IDX_OFS[c]) begin
        r_next.idx[c] = reg_wdata[SW-1:0] &
                        (csi_pkg::DBL_CHAN[c] ? csi_pkg::DBL_MASK : csi_pkg::SIMPLE_MASK);
        // Alternation restarts on the first index after a rewrite
        r_next.alt[c] = 1'b0;
      end
      // Frame source choice to the channel
      r_next.vsel[c] = r_reg.idx[c][csi_pkg::VSEL_BIT];
      r_next.act[c] = pick_index(r_reg.idx[c], r_reg.alt[c], csi_pkg::DBL_CHAN[c]);
      if (reg_rd && reg_addr == csi_pkg::IDX_OFS[c]) begin
        r_next.rdata = {{(DW - SW){1'b0}}, r_reg.idx[c]};
      end
    end
    for (int k = 0; k < NC; k++) begin
      // Counter field only, the rest zero
      if (reg_rd && reg_addr == csi_pkg::CNT_OFS[k]) begin
        r_next.rdata = {{(DW - csi_pkg::Y_LSB - Y_W){1'b0}}, cnt[k],
                        {csi_pkg::Y_LSB{1'b0}}};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign surface_index = r_reg.act;
  assign vsync_sel = r_reg.vsel;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  idle_read_zero_a: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("Read data not zero outside a read answer");

  index_write_read_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[0] ##1 reg_rd && reg_addr == csi_pkg::IDX_OFS[0]
    |=> reg_rdata[IW-1:0] == $past(reg_wdata[IW-1:0], 2))
    else $error("Index did not read back as written");

  simple_mask_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[1]
    |=> r_reg.idx[1][13:8] == '0 && r_reg.idx[1][6:4] == '0)
    else $error("Reserved index bits were stored");

  dual_field_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[5]
    |=> r_reg.idx[5][11:8] == $past(reg_wdata[11:8]) && r_reg.idx[5][6:4] == '0)
    else $error("Second index not stored");

  vsync_follow_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[3]
    |=> ##1 vsync_sel[3] == $past(reg_wdata[csi_pkg::VSEL_BIT], 2))
    else $error("Frame source select did not follow write");

  mode_first_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[2] && reg_wdata[13:12] == 2'h0
    ##1 !(reg_wr && reg_addr == csi_pkg::IDX_OFS[2])
    |=> surface_index[2] == $past(reg_wdata[3:0], 2))
    else $error("Mode 0 did not use the first index");

  mode_second_a: assert property (
    reg_wr && reg_addr == csi_pkg::IDX_OFS[5] && reg_wdata[13:12] == 2'h1
    ##1 !(reg_wr && reg_addr == csi_pkg::IDX_OFS[5])
    |=> surface_index[5] == $past(reg_wdata[11:8], 2))
    else $error("Mode 1 did not use the second index");

  alt_flip_a: assert property (
    mode_of(r_reg.idx[7]) == csi_pkg::CSI_MODE_ALT &&
    disp_frame_start[r_reg.idx[7][csi_pkg::VSEL_BIT]] &&
    !(reg_wr && reg_addr == csi_pkg::IDX_OFS[7])
    |=> r_reg.alt[7] != $past(r_reg.alt[7]))
    else $error("Alternating channel did not flip at frame start");

  alt_hold_a: assert property (
    mode_of(r_reg.idx[2]) != csi_pkg::CSI_MODE_ALT &&
    !(reg_wr && reg_addr == csi_pkg::IDX_OFS[2])
    |=> $stable(r_reg.alt[2]))
    else $error("Non-alternating channel changed buffer");

  counter_read_a: assert property (
    reg_rd && reg_addr == csi_pkg::CNT_OFS[8]
    |=> reg_rdata[27:16] == $past(cnt[8]))
    else $error("Counter read value wrong");

  simple_index_a: assert property (
    1'b1 |=> surface_index[0] == $past(r_reg.idx[0][3:0]))
    else $error("Plain channel index not shown");

  alt_source_a: assert property (
    disp_frame_start[~r_reg.idx[2][csi_pkg::VSEL_BIT]] &&
    !disp_frame_start[r_reg.idx[2][csi_pkg::VSEL_BIT]] &&
    !(reg_wr && reg_addr == csi_pkg::IDX_OFS[2])
    |=> $stable(r_reg.alt[2]))
    else $error("Buffer flipped on the unselected frame source");

  counter_reserved_a: assert property (
    reg_rd && reg_addr == csi_pkg::CNT_OFS[0]
    |=> reg_rdata[15:0] == '0 && reg_rdata[31:28] == '0)
    else $error("Reserved counter bits not zero");

endmodule

/* verification/csi_top_tb_top.sv */
`timescale 1ns/1ps
module csi_top_tb_top;
  logic core_clk, nrst, reg_wr, reg_rd, rd_d;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] line_strobe, frame_strobe;
  logic [8:0][11:0] y_start;
  logic [1:0] disp_frame_start;
  logic [7:0][3:0] surface_index;
  logic [7:0] vsync_sel;
  logic [31:0] exp_q[$];
  logic [31:0] wd[8];
  logic [11:0] ys[9];
  int n_mismatch, samples_checked, n;

  csi_top dut_u (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_strobe, .frame_strobe, .y_start, .disp_frame_start, .surface_index, .vsync_sel);

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk_data(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR reg_rdata exp %h got %h", e, g);
    end
  endtask

  task chk_chan(input int c, input logic [4:0] e);
    samples_checked++;
    if ({vsync_sel[c], surface_index[c]} !== e) begin
      n_mismatch++;
      $display("ERROR channel %0d exp %h got %h", c, e, {vsync_sel[c], surface_index[c]});
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 0;
  endtask

  task pulse(input logic [1:0] v);
    @(posedge core_clk);
    disp_frame_start <= v;
    @(posedge core_clk);
    disp_frame_start <= 0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Data stands only one cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk_data(exp_q.pop_front(), reg_rdata);
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {line_strobe, frame_strobe, y_start, disp_frame_start} = '0;
    void'($urandom(56));
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    for (int c = 0; c < 8; c++) rd(csi_pkg::IDX_OFS[c], 32'h0000_0000);
    for (int c = 0; c < 9; c++) rd(csi_pkg::CNT_OFS[c], 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      wd[c] = $urandom;
      // Software never programs the reserved mode
      if (wd[c][13:12] == 2'h3) wd[c][13] = 1'b0;
      wr(csi_pkg::IDX_OFS[c], wd[c]);
    end
    // Reserved bits drop out of readback
    for (int c = 0; c < 8; c++) rd(csi_pkg::IDX_OFS[c], wd[c] & {18'h0, csi_pkg::DBL_CHAN[c] ?
      csi_pkg::DBL_MASK : csi_pkg::SIMPLE_MASK});
    repeat (2) @(posedge core_clk);
    #1;
    for (int c = 0; c < 8; c++) chk_chan(c, {wd[c][7], (csi_pkg::DBL_CHAN[c] &&
      wd[c][13:12] == 2'h1) ? wd[c][11:8] : wd[c][3:0]});
    // Reserved mode 3 left out on purpose
    for (int m = 0; m < 3; m++) begin
      wr(12'hb74, 32'h0000_0a83 | (32'(m) << 12));
      repeat (3) @(posedge core_clk);
      #1;
      chk_chan(5, {1'b1, m == 1 ? 4'ha : 4'h3});
    end
    // Frame and line together: reload wins
    @(posedge core_clk);
    for (int c = 0; c < 9; c++) ys[c] = (c == 8) ? 12'hfff : 12'($urandom);
    for (int c = 0; c < 9; c++) y_start[c] <= ys[c];
    frame_strobe <= '1;
    line_strobe <= '1;
    n = $urandom_range(1, 5);
    @(posedge core_clk);
    frame_strobe <= '0;
    repeat (n) @(posedge core_clk);
    line_strobe <= '0;
    for (int c = 0; c < 9; c++) rd(csi_pkg::CNT_OFS[c], {4'h0, ys[c] + 12'(n), 16'h0});
    wr(csi_pkg::CNT_OFS[3], 32'hffff_ffff);
    rd(csi_pkg::CNT_OFS[3], {4'h0, ys[3] + 12'(n), 16'h0});
    rd(12'hb00, 32'h0000_0000);
    // Scaler 0 alternates on display 1 frames
    wr(12'hb24, 32'h0000_2983);
    pulse(2'b01);
    chk_chan(2, 5'h13);
    pulse(2'b10);
    chk_chan(2, 5'h19);
    wr(12'hb24, 32'h0000_2983);
    repeat (3) @(posedge core_clk);
    #1;
    chk_chan(2, 5'h13);
    wr(12'hbe4, 32'h0000_2045);
    pulse(2'b01);
    chk_chan(7, 5'h00);
    chk_chan(2, 5'h13);
    repeat (3) @(posedge core_clk);
    tally_and_finish;
  end
endmodule
